// ---- hw/css_pkg.sv ----
// Constants shared by the clock source selector
// Assumes a 100 MHz system clock and a 32-bit classic Wishbone bus
package css_pkg;

    // =========================================
    // Clock and rate limits
    localparam int CLK_HZ          = 100_000_000;
    localparam int IN_RATE_MIN_HZ  = 25_000;
    localparam int IN_RATE_MAX_HZ  = 105_000;
    localparam int WCK_RATE_MAX_HZ = 103_000;
    localparam int PER_W           = 13;
    localparam logic [12:0] PERIOD_MAX     = 13'(CLK_HZ / IN_RATE_MIN_HZ);
    localparam logic [12:0] PERIOD_MIN_IN  = 13'((CLK_HZ + IN_RATE_MAX_HZ - 1) / IN_RATE_MAX_HZ);
    localparam logic [12:0] PERIOD_MIN_WCK = 13'((CLK_HZ + WCK_RATE_MAX_HZ - 1) / WCK_RATE_MAX_HZ);
    localparam logic [12:0] PERIOD_TOL     = 13'h010;

    // =========================================
    // Playback rates
    localparam int RATE_32K_HZ = 32_000;
    localparam int RATE_44K_HZ = 44_100;
    localparam int RATE_48K_HZ = 48_000;
    localparam int RATE_88K_HZ = 88_200;
    localparam int RATE_96K_HZ = 96_000;
    localparam logic [2:0] RATE_32K = 3'h0;
    localparam logic [2:0] RATE_44K = 3'h1;
    localparam logic [2:0] RATE_48K = 3'h2;
    localparam logic [2:0] RATE_88K = 3'h3;
    localparam logic [2:0] RATE_96K = 3'h4;

    // =========================================
    // Clock inputs
    localparam int NUM_IN = 4;
    localparam logic [1:0] IN_OPTICAL = 2'h0;
    localparam logic [1:0] IN_STEREO  = 2'h1;
    localparam logic [1:0] IN_WORDCLK = 2'h2;
    localparam logic [1:0] IN_SYNC    = 2'h3;

    // =========================================
    // Register map
    localparam logic [7:0] ADDR_CTRL       = 8'h00;
    localparam logic [7:0] ADDR_STATUS     = 8'h04;
    localparam logic [7:0] ADDR_REF_PERIOD = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_MASK   = 8'h10;
    localparam int CTRL_AUTO_BIT = 0;
    localparam int CTRL_PREF_LSB = 1;
    localparam int CTRL_RATE_LSB = 3;
    localparam logic       CTRL_AUTO_RST = 1'b1;
    localparam logic [1:0] CTRL_PREF_RST = 2'h0;
    localparam logic [2:0] CTRL_RATE_RST = 3'h2;
    localparam int ST_SLAVE_BIT = 0;
    localparam int ST_REF_LSB   = 1;
    localparam int ST_SPLIT_BIT = 3;
    localparam int ST_LOCK_LSB  = 4;
    localparam int IRQ_REF_CHANGE = 0;
    localparam int IRQ_FALLBACK   = 1;
    localparam int IRQ_LOCK_LOST  = 2;
    localparam int IRQ_W          = 3;

    typedef enum logic [1:0] {LK_NONE, LK_LOCK, LK_SYNC} css_lock_t;

endpackage : css_pkg

// ---- hw/css_rate_meter.sv ----
// Period meter for one input frame clock
// Assumes the frame clock is asynchronous to clk_sys
module css_rate_meter #(
    parameter logic [12:0] MIN_PERIOD = css_pkg::PERIOD_MIN_IN
) (
    // System
    input  wire logic        clk_sys,
    input  wire logic        reset,
    // Frame clock pin
    input  wire logic        frameClk,
    // Measurement
    output logic             valid,
    output logic [12:0]      period
);

    // =========================================
    // Synchroniser and edge detect
    logic        syncA;
    logic        syncB;
    logic        prevB;
    logic [12:0] cnt;
    wire         rise     = syncB & ~prevB;
    wire         inRange  = (cnt >= MIN_PERIOD) && (cnt <= css_pkg::PERIOD_MAX);
    wire         timedOut = cnt > css_pkg::PERIOD_MAX;

    always_ff @(posedge clk_sys) begin
        syncA <= frameClk;
        syncB <= syncA;
        prevB <= syncB;
    end

    // =========================================
    // Period counter and validity
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cnt    <= 13'h1FFF;
            valid  <= 1'b0;
            period <= 13'h0000;
        end else if (rise) begin
            cnt    <= 13'h0001;
            valid  <= inRange;
            period <= inRange ? cnt : 13'h0000;
        end else begin
            if (!cnt[12] || !(&cnt[11:0]))
                cnt <= cnt + 13'h0001;
            if (timedOut)
                valid <= 1'b0;
        end
    end

    a_period_capture: assert property (@(posedge clk_sys) disable iff (reset)
        rise && inRange |=> valid && period == $past(cnt))
        else $error("period not captured on a valid edge");
    a_timeout_drop: assert property (@(posedge clk_sys) disable iff (reset)
        timedOut && !rise |=> !valid)
        else $error("valid kept after input went silent");

endmodule : css_rate_meter

// ---- hw/css_clock_source_selector.sv ----
// Clock source selector: master or recovered-clock slave with automatic reference choice
// Assumes frame clocks arrive on pins and software works over classic Wishbone
module css_clock_source_selector (
    // System
    input  wire logic        clk_sys,
    input  wire logic        reset,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Input frame clocks
    input  wire logic [3:0]  frameClk,
    // Clock control
    output logic      [3:0]  refSelect,
    output logic             slaveMode,
    output logic             rateSplit,
    output logic             irq
);

    // =========================================
    // Decode functions
    function automatic logic [12:0] expectedPeriod(input logic [2:0] rs, input logic half);
        logic [12:0] p;
        p = 13'((css_pkg::CLK_HZ + css_pkg::RATE_48K_HZ / 2) / css_pkg::RATE_48K_HZ);
        case (rs)
            css_pkg::RATE_32K:
                p = 13'((css_pkg::CLK_HZ + css_pkg::RATE_32K_HZ / 2) / css_pkg::RATE_32K_HZ);
            css_pkg::RATE_44K:
                p = 13'((css_pkg::CLK_HZ + css_pkg::RATE_44K_HZ / 2) / css_pkg::RATE_44K_HZ);
            css_pkg::RATE_88K:
                p = 13'((css_pkg::CLK_HZ + css_pkg::RATE_88K_HZ / 2) / css_pkg::RATE_88K_HZ);
            css_pkg::RATE_96K:
                p = 13'((css_pkg::CLK_HZ + css_pkg::RATE_96K_HZ / 2) / css_pkg::RATE_96K_HZ);
            default:
                p = 13'((css_pkg::CLK_HZ + css_pkg::RATE_48K_HZ / 2) / css_pkg::RATE_48K_HZ);
        endcase
        // Rate-split optical frames run at half the selected rate
        return half ? {p[11:0], 1'b0} : p;
    endfunction : expectedPeriod

    function automatic logic nearPeriod(input logic [12:0] meas, input logic [12:0] want);
        return (meas + css_pkg::PERIOD_TOL >= want) && (meas <= want + css_pkg::PERIOD_TOL);
    endfunction : nearPeriod

    // =========================================
    // Control registers
    logic                  autoMode;
    logic [1:0]            prefRef;
    logic [2:0]            rateSel;
    logic [1:0]            activeRef;
    logic [12:0]           refPeriod;
    logic [7:0]            lockState;
    logic [css_pkg::IRQ_W-1:0] irqStatus;
    logic [css_pkg::IRQ_W-1:0] irqMask;

    // =========================================
    // Per-input measurement
    logic [3:0]            inValid;
    logic [12:0]           inPeriod [4];
    logic [3:0]            inMatch;
    logic [7:0]            lockCode;
    wire                   splitNow = (rateSel == css_pkg::RATE_88K) || (rateSel == css_pkg::RATE_96K);

    genvar g;
    generate
        for (g = 0; g < css_pkg::NUM_IN; g = g + 1) begin : gen_in
            // Word clock input has a lower upper rate
            css_rate_meter #(
                .MIN_PERIOD(g == 2 ? css_pkg::PERIOD_MIN_WCK : css_pkg::PERIOD_MIN_IN)
            ) u_meter (
                .clk_sys  (clk_sys),
                .reset    (reset),
                .frameClk (frameClk[g]),
                .valid    (inValid[g]),
                .period   (inPeriod[g])
            );
            // All four inputs are measured in parallel
            assign inMatch[g] = inValid[g] &&
                nearPeriod(inPeriod[g], expectedPeriod(rateSel, (g == 0) && splitNow));
            assign lockCode[2*g+1:2*g] = !inValid[g] ? css_pkg::LK_NONE :
                                         inMatch[g]  ? css_pkg::LK_SYNC : css_pkg::LK_LOCK;
        end
    endgenerate

    // =========================================
    // Reference selection
    wire [3:0] cand  = inMatch;
    wire [1:0] pick1 = prefRef + 2'h1;
    wire [1:0] pick2 = prefRef + 2'h2;
    wire [1:0] pick3 = prefRef + 2'h3;
    wire       anyCand = |cand;
    wire [1:0] next_ref = cand[prefRef] ? prefRef :
                          cand[pick1]   ? pick1   :
                          cand[pick2]   ? pick2   : pick3;
    wire       next_slave = autoMode && anyCand;
    wire [3:0] next_select = next_slave ? (4'h1 << next_ref) : 4'h0;

    // =========================================
    // Events
    wire evRefChange = (next_slave != slaveMode) || (next_slave && (next_ref != activeRef));
    wire evFallback  = slaveMode && !next_slave && autoMode;
    logic [3:0] prevValid;
    wire evLockLost  = |(prevValid & ~inValid);
    wire [css_pkg::IRQ_W-1:0] events;
    assign events[css_pkg::IRQ_REF_CHANGE] = evRefChange;
    assign events[css_pkg::IRQ_FALLBACK]   = evFallback;
    assign events[css_pkg::IRQ_LOCK_LOST]  = evLockLost;

    // =========================================
    // Wishbone decode
    wire wbReq   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // Write lands at the edge where the master samples ack
    wire wbWrite = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
    wire hitCtrl = wb_adr_i == css_pkg::ADDR_CTRL;
    wire hitStat = wb_adr_i == css_pkg::ADDR_STATUS;
    wire hitPer  = wb_adr_i == css_pkg::ADDR_REF_PERIOD;
    wire hitIrqS = wb_adr_i == css_pkg::ADDR_IRQ_STATUS;
    wire hitIrqM = wb_adr_i == css_pkg::ADDR_IRQ_MASK;
    wire [css_pkg::IRQ_W-1:0] irqClear = (wbWrite && hitIrqS) ? wb_dat_i[css_pkg::IRQ_W-1:0] : '0;
    // Set wins over a clear in the same cycle
    wire [css_pkg::IRQ_W-1:0] next_irqStatus = (irqStatus & ~irqClear) | events;

    wire [31:0] ctrlWord = {26'h0000000, rateSel, prefRef, autoMode};
    wire [31:0] statWord = {20'h00000, lockState, rateSplit, activeRef, slaveMode};
    wire [31:0] perWord  = {19'h00000, refPeriod};
    wire [31:0] irqSWord = {29'h00000000, irqStatus};
    wire [31:0] irqMWord = {29'h00000000, irqMask};
    wire [31:0] readMux  = hitCtrl ? ctrlWord :
                           hitStat ? statWord :
                           hitPer  ? perWord  :
                           hitIrqS ? irqSWord :
                           hitIrqM ? irqMWord : 32'h00000000;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wbReq;
            wb_dat_o <= (wbReq && !wb_we_i) ? readMux : 32'h00000000;
        end
    end

    // =========================================
    // Software settings
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            autoMode <= css_pkg::CTRL_AUTO_RST;
            prefRef  <= css_pkg::CTRL_PREF_RST;
            rateSel  <= css_pkg::CTRL_RATE_RST;
            irqMask  <= '0;
        end else if (wbWrite) begin
            if (hitCtrl) begin
                autoMode <= wb_dat_i[css_pkg::CTRL_AUTO_BIT];
                prefRef  <= wb_dat_i[css_pkg::CTRL_PREF_LSB +: 2];
                rateSel  <= wb_dat_i[css_pkg::CTRL_RATE_LSB +: 3];
            end
            if (hitIrqM)
                irqMask <= wb_dat_i[css_pkg::IRQ_W-1:0];
        end
    end

    // =========================================
    // Clock state
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            slaveMode <= 1'b0;
            activeRef <= css_pkg::IN_OPTICAL;
            refSelect <= 4'h0;
            refPeriod <= 13'h0000;
            rateSplit <= 1'b0;
            lockState <= 8'h00;
            prevValid <= 4'h0;
        end else begin
            slaveMode <= next_slave;
            refSelect <= next_select;
            if (next_slave)
                activeRef <= next_ref;
            refPeriod <= next_slave ? inPeriod[next_ref] : 13'h0000;
            rateSplit <= splitNow;
            lockState <= lockCode;
            prevValid <= inValid;
        end
    end

    // =========================================
    // Interrupts
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            irqStatus <= '0;
            irq       <= 1'b0;
        end else begin
            irqStatus <= next_irqStatus;
            irq       <= |(next_irqStatus & irqMask);
        end
    end

    // =========================================
    // Checks
    a_master_forced: assert property (@(posedge clk_sys) disable iff (reset)
        !autoMode |=> !slaveMode && refSelect == 4'h0)
        else $error("input clock used in master mode");
    a_fallback_master: assert property (@(posedge clk_sys) disable iff (reset)
        autoMode && cand == 4'h0 |=> !slaveMode)
        else $error("no fallback to master without valid input");
    a_slave_on_match: assert property (@(posedge clk_sys) disable iff (reset)
        autoMode && anyCand |=> slaveMode && refSelect != 4'h0)
        else $error("matching input not adopted");
    a_pref_wins: assert property (@(posedge clk_sys) disable iff (reset)
        autoMode && cand[prefRef] |=> activeRef == $past(prefRef))
        else $error("preferred input not used while valid");
    a_first_avail: assert property (@(posedge clk_sys) disable iff (reset)
        autoMode && !cand[prefRef] && cand[pick1] |=> activeRef == $past(pick1))
        else $error("first available input not adopted");
    a_rotation_order: assert property (@(posedge clk_sys) disable iff (reset)
        autoMode && cand == (4'h1 << pick3) |=> activeRef == $past(pick3))
        else $error("rotation did not reach last input");
    a_single_ref: assert property (@(posedge clk_sys) disable iff (reset)
        $onehot0(refSelect) && (slaveMode == (refSelect != 4'h0)))
        else $error("more than one reference selected");
    a_ref_onehot_idx: assert property (@(posedge clk_sys) disable iff (reset)
        slaveMode |-> refSelect[activeRef] && refPeriod == $past(inPeriod[next_ref]))
        else $error("reference index or period mismatch");
    a_split_follow: assert property (@(posedge clk_sys) disable iff (reset)
        ##1 rateSplit == ($past(rateSel) == css_pkg::RATE_88K || $past(rateSel) == css_pkg::RATE_96K))
        else $error("rate-split flag wrong");
    a_lock_report: assert property (@(posedge clk_sys) disable iff (reset)
        !inValid[1] |=> lockState[3:2] == css_pkg::LK_NONE)
        else $error("lock reported without signal");
    a_sticky_set: assert property (@(posedge clk_sys) disable iff (reset)
        evRefChange |=> irqStatus[css_pkg::IRQ_REF_CHANGE])
        else $error("event lost against clear");
    a_ack_single: assert property (@(posedge clk_sys) disable iff (reset)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

endmodule : css_clock_source_selector

// ---- dv/css_frame_src.sv ----
// Partner model: frame clocks from the external digital audio sources
// Assumes the bench sets ticks; zero ticks keeps a line silent and low
module css_frame_src (
    // Frame periods in 125 ns link ticks, zero means silent
    input  wire logic [3:0][8:0] ticks,
    // Frame clock pins
    output logic      [3:0]      frameClk
);
    timeunit 1ns;
    timeprecision 100ps;
    // ========================================
    // Link clock, phase unrelated to clk_sys
    logic       linkClk;
    logic [8:0] cnt [4];
    initial begin
        linkClk  = 1'b0;
        frameClk = 4'h0;
        for (int i = 0; i < 4; i++) begin
            cnt[i] = 9'h000;
        end
        #3.3;
        forever #62.5 linkClk = ~linkClk;
    end
    // ========================================
    // Frame clock dividers
    always @(posedge linkClk) begin
        for (int i = 0; i < 4; i++) begin
            if (ticks[i] == 9'h000) begin
                cnt[i]      <= 9'h000;
                frameClk[i] <= 1'b0;
            end else begin
                cnt[i]      <= (cnt[i] >= ticks[i] - 9'h001) ? 9'h000 : cnt[i] + 9'h001;
                frameClk[i] <= cnt[i] < (ticks[i] >> 1);
            end
        end
    end
endmodule : css_frame_src

// ---- dv/test_clock_source_selector.sv ----
// Self-checking bench for the clock source selector
// Assumes frame clocks from css_frame_src and a 100 MHz clk_sys
module test_clock_source_selector;
    timeunit 1ns;
    timeprecision 100ps;
    // ========================================
    // Signals
    logic             clk_sys, reset, wbCyc, wbStb, wbWe;
    logic [7:0]       wbAdr;
    logic [31:0]      wbDat, q;
    logic [3:0][8:0]  ticks;
    logic [3:0]       frameClk, refSelect;
    logic             slaveMode, rateSplit, irq;
    wire  logic [31:0] wbDatO;
    wire  logic       wbAck;
    int               errCount, checked;
    // ========================================
    // Design and partner
    css_clock_source_selector i_dut (.clk_sys(clk_sys), .reset(reset), .wb_cyc_i(wbCyc),
        .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hF),
        .wb_dat_i(wbDat), .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .frameClk(frameClk),
        .refSelect(refSelect), .slaveMode(slaveMode), .rateSplit(rateSplit), .irq(irq));
    css_frame_src i_src (.ticks(ticks), .frameClk(frameClk));
    // ========================================
    // Helpers
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            errCount++;
            $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
        end
    endtask : chk
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        {wbCyc, wbStb, wbWe, wbAdr, wbDat} <= {1'b1, 1'b1, we, a, d};
        do begin
            @(posedge clk_sys);
        end while (wbAck !== 1'b1);
        q = wbDatO;
        {wbCyc, wbStb} <= 2'b00;
        @(posedge clk_sys);
        chk("busAckDrop", 32'h0, 32'(wbAck));
    endtask : wb
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : wait_clk
    function automatic logic [31:0] lk(input logic [31:0] s, input int i);
        return 32'(s[4 + 2 * i +: 2]);
    endfunction : lk
    // ========================================
    // Scenarios
    task automatic s_reset;
        wb(0, css_pkg::ADDR_CTRL, 0); chk("ctrl", 32'h0000_0011, q);
        wb(0, css_pkg::ADDR_IRQ_MASK, 0); chk("irqMask", 32'h0, q);
        wb(0, css_pkg::ADDR_STATUS, 0); chk("status", 32'h0, q);
        wb(0, 8'h14, 0); chk("unmapped", 32'h0, q);
        chk("irq", 32'h0, 32'(irq));
    endtask : s_reset
    task automatic s_master;
        wb(1, css_pkg::ADDR_CTRL, 32'h0000_0010);
        ticks[1] = 9'd167;
        wait_clk(8500);
        chk("slaveMode", 32'h0, 32'(slaveMode));
        chk("refSelect", 32'h0, 32'(refSelect));
    endtask : s_master
    task automatic s_auto;
        wb(1, css_pkg::ADDR_CTRL, 32'h0000_0011);
        wait_clk(8500);
        chk("slaveMode", 32'h1, 32'(slaveMode));
        chk("refSelect", 32'h2, 32'(refSelect));
        wb(0, css_pkg::ADDR_STATUS, 0); chk("statusLow", 32'h3, q & 32'h7);
        chk("lockOpt", css_pkg::LK_NONE, lk(q, 0));
        chk("lockSt", css_pkg::LK_SYNC, lk(q, 1));
        wb(0, css_pkg::ADDR_REF_PERIOD, 0); chk("refPer", 1, 32'(q >= 2080 && q <= 2095));
    endtask : s_auto
    task automatic s_pref;
        ticks[2] = 9'd167;
        wb(1, css_pkg::ADDR_CTRL, 32'h0000_0015);
        wait_clk(8500);
        chk("refPref", 32'h4, 32'(refSelect));
        wb(1, css_pkg::ADDR_CTRL, 32'h0000_0017);
        wait_clk(8);
        chk("refScan", 32'h2, 32'(refSelect));
        ticks[1] = 9'd0;
        ticks[3] = 9'd181;
        wait_clk(8500);
        chk("refRot", 32'h4, 32'(refSelect));
        wb(0, css_pkg::ADDR_STATUS, 0);
        chk("lockSp", css_pkg::LK_LOCK, lk(q, 3));
        chk("lockWc", css_pkg::LK_SYNC, lk(q, 2));
    endtask : s_pref
    task automatic s_fallback;
        wb(1, css_pkg::ADDR_IRQ_STATUS, 32'h7);
        ticks = '0;
        wait_clk(8500);
        chk("slaveMode", 32'h0, 32'(slaveMode));
        chk("refSelect", 32'h0, 32'(refSelect));
        wb(0, css_pkg::ADDR_IRQ_STATUS, 0); chk("irqFall", 32'h2, q & 32'h2);
        chk("irqMasked", 32'h0, 32'(irq));
        wb(1, css_pkg::ADDR_IRQ_MASK, 32'h2);
        wait_clk(2);
        chk("irqHigh", 32'h1, 32'(irq));
        wb(1, css_pkg::ADDR_IRQ_STATUS, 32'h2);
        wait_clk(2);
        chk("irqClr", 32'h0, 32'(irq));
    endtask : s_fallback
    task automatic s_range;
        ticks = {9'd267, 9'd77, 9'd77, 9'd0};
        wait_clk(8500);
        wb(0, css_pkg::ADDR_STATUS, 0);
        chk("lock104k", css_pkg::LK_LOCK, lk(q, 1));
        chk("lockWc104k", css_pkg::LK_NONE, lk(q, 2));
        chk("lock30k", css_pkg::LK_LOCK, lk(q, 3));
    endtask : s_range
    task automatic s_split;
        for (int c = 0; c < 5; c++) begin
            wb(1, css_pkg::ADDR_CTRL, (32'(c) << 3) | 32'h1);
            wait_clk(2);
            chk("rateSplit", 32'(c >= 3), 32'(rateSplit));
        end
        ticks = {9'd0, 9'd0, 9'd83, 9'd167};
        wait_clk(8500);
        chk("refSplit", 32'h1, 32'(refSelect));
        wb(0, css_pkg::ADDR_STATUS, 0); chk("splitBit", 32'h8, q & 32'h8);
        chk("lockOpt", css_pkg::LK_SYNC, lk(q, 0));
        chk("lockSt", css_pkg::LK_SYNC, lk(q, 1));
        wb(0, css_pkg::ADDR_REF_PERIOD, 0); chk("optPer", 1, 32'(q >= 2080 && q <= 2095));
    endtask : s_split
    // ========================================
    // Verdict
    task automatic end_of_test;
        $display("Comparisons %0d mismatches %0d", checked, errCount);
        if (errCount == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test
    // ========================================
    // Clock, watchdog, main sequence
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        #800_000;
        errCount++;
        end_of_test();
    end
    initial begin
        {reset, wbCyc, wbStb, wbWe, wbAdr, wbDat} = {1'b1, 43'h0};
        ticks = '0;
        errCount = 0;
        checked = 0;
        wait_clk(4);
        reset <= 1'b0;
        s_reset();
        s_master();
        s_auto();
        s_pref();
        s_fallback();
        s_range();
        s_split();
        end_of_test();
    end
endmodule : test_clock_source_selector
